//--- drc_pkg.sv
// shared constants and types for the drive run command logic
package drc_pkg;

  // ------------------------------------------------------------
  // command sources and selector codes
  // ------------------------------------------------------------
  localparam logic [1:0] SRC_PANEL = 2'h0; // panel keys, led off
  localparam logic [1:0] SRC_TERM = 2'h1; // terminals, led steady
  localparam logic [1:0] SRC_COMM = 2'h2; // serial link, led flashing
  localparam logic SCHEME_2W = 1'h0; // two-wire switch levels
  localparam logic SCHEME_3W = 1'h1; // three-wire pushbuttons
  localparam logic [1:0] START_DIRECT = 2'h0; // direct start
  localparam logic [1:0] START_TRACK = 2'h1; // speed tracking restart
  localparam logic [1:0] START_PREEX = 2'h2; // pre-excitation start
  localparam logic STOP_DECEL = 1'h0; // ramp down
  localparam logic STOP_COAST = 1'h1; // free coast
  localparam logic [1:0] CTRL_VF = 2'h2; // v/f; 0, 1 and 3 are vector
  localparam logic [2:0] MFK_REV_JOG = 3'h4; // key acts as reverse jog

  // ------------------------------------------------------------
  // digital input function codes
  // ------------------------------------------------------------
  localparam logic [3:0] FN_NONE = 4'h0; // input unused
  localparam logic [3:0] FN_FWD = 4'h1; // forward run / start button
  localparam logic [3:0] FN_REV = 4'h2; // reverse run / start button
  localparam logic [3:0] FN_PERMIT = 4'h3; // three-wire stop permit
  localparam logic [3:0] FN_JOG_FWD = 4'h4; // forward jog
  localparam logic [3:0] FN_JOG_REV = 4'h5; // reverse jog

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 20; // 50 MHz system clock
  localparam int TICK_NS = 1000000; // 1 ms timebase
  localparam int TICK_CYCLES = TICK_NS / CLK_NS; // exact division
  localparam int FLASH_MS = 250; // half period of the flashing led
  localparam int COMM_UNIT_MS = 100; // comm timeout counts 0.1 s
  localparam int TS_UNIT_MS = 60000; // timed stop counts minutes
  localparam int TW = 16; // width of time fields

  // run state, gray along idle-run-stop and idle-jog-stop; stop-idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_STOP = 2'h3,
    ST_JOG = 2'h2
  } drc_state_t;

  // requests of the selected source for one cycle
  typedef struct packed {
    logic start; // start or change direction
    logic rev; // direction of the start
    logic stop; // stop request
    logic jog; // forward jog held
    logic jog_rev; // reverse jog held
  } drc_req_t;

  // command bundle towards the motor control
  typedef struct packed {
    logic run; // output stage active
    logic reverse; // direction
    logic jog; // low jog speed
    logic decel; // ramping down
    logic coast; // release output, coast
    logic [1:0] startup; // start-up method
    logic vector; // vector control, else v/f
  } drc_drive_t;

endpackage

//--- drc_tick_timer.sv
// unit timer counting millisecond ticks up to a programmable limit
`timescale 1ns/1ns
`default_nettype none
module drc_tick_timer #(
  parameter int W = 16,
  parameter int UNIT_TICKS = 100
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic enable,
  input wire logic restart,
  input wire logic [W-1:0] limit,
  output logic expired
);
  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (W < 1 || UNIT_TICKS < 2) begin : g_bad
    $error("drc_tick_timer: unsupported width or unit");
  end

  localparam int UW = $clog2(UNIT_TICKS); // sub-unit counter width

  logic [UW-1:0] sub_r; // ticks inside the current unit
  logic [W-1:0] units_r; // whole units elapsed
  logic expired_r; // limit reached, held until restart or disable

  // ------------------------------------------------------------
  // counting; a zero limit never expires
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sub_r <= '0;
      units_r <= '0;
      expired_r <= 1'b0;
    end else if (!enable || restart) begin
      // idle or fresh start: count from zero
      sub_r <= '0;
      units_r <= '0;
      expired_r <= 1'b0;
    end else if (limit != '0 && units_r >= limit) begin
      expired_r <= 1'b1; // saturate here, no wrap
    end else if (tick) begin
      if (sub_r == UW'(UNIT_TICKS - 1)) begin
        sub_r <= '0;
        units_r <= units_r + 1'b1;
      end else begin
        sub_r <= sub_r + 1'b1;
      end
    end
  end

  assign expired = expired_r;
endmodule
`default_nettype wire

//--- drc_top.sv
// drive run command logic: source select, run state, stop timers
`timescale 1ns/1ns
`default_nettype none
module drc_top #(
  parameter int N_DI = 10,
  parameter int TICK_CYCLES = drc_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [1:0] command_source_select,
  input wire logic terminal_command_scheme,
  input wire logic [N_DI-1:0][3:0] input_function_select,
  input wire logic [N_DI-1:0] di_level,
  input wire logic key_run,
  input wire logic key_stop,
  input wire logic key_jog,
  input wire logic key_multi,
  input wire logic [2:0] multifunction_key_select,
  input wire logic reverse_inhibit,
  input wire logic comm_frame_valid,
  input wire logic comm_run_fwd,
  input wire logic comm_run_rev,
  input wire logic comm_stop,
  input wire logic [drc_pkg::TW-1:0] comm_timeout_time,
  input wire logic comm_fault_clear,
  input wire logic [1:0] startup_mode_select,
  input wire logic motor_is_induction,
  input wire logic stop_mode_select,
  input wire logic timed_stop_enable,
  input wire logic timed_stop_duration_source,
  input wire logic [drc_pkg::TW-1:0] timed_stop_duration_value,
  input wire logic [drc_pkg::TW-1:0] timed_stop_analog,
  input wire logic [1:0] motor_control_method,
  input wire logic decel_done,
  output var drc_pkg::drc_drive_t drive,
  output logic run_led,
  output logic source_led,
  output logic comm_fault
);
  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  if (N_DI < 3 || TICK_CYCLES < 2) begin : g_bad
    $error("drc_top: need three inputs and a tick of two cycles");
  end

  localparam int TCW = $clog2(TICK_CYCLES); // tick divider width
  localparam int FLW = $clog2(drc_pkg::FLASH_MS); // flash counter

  // any active input carrying a given role
  function automatic logic di_any(input logic [N_DI-1:0] lv,
                                  input logic [N_DI-1:0][3:0] fs,
                                  input logic [3:0] code);
    di_any = 1'b0;
    for (int i = 0; i < N_DI; i++) begin
      if (lv[i] && fs[i] == code) begin
        di_any = 1'b1;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync_r; // release shift, async assert
  logic rst_n; // internal reset copy

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ------------------------------------------------------------
  // millisecond tick and led flash divider
  // ------------------------------------------------------------
  logic [TCW-1:0] tick_cnt_r; // cycles inside one millisecond
  logic tick_r; // one-cycle millisecond enable
  logic [FLW-1:0] flash_cnt_r; // ticks inside one flash phase
  logic flash_r; // flashing led phase

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TCW'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_r <= '0;
      flash_r <= 1'b0;
    end else if (tick_r) begin
      if (flash_cnt_r == FLW'(drc_pkg::FLASH_MS - 1)) begin
        flash_cnt_r <= '0;
        flash_r <= !flash_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // terminal roles and closing edges
  // ------------------------------------------------------------
  logic fwd_lvl, rev_lvl, permit_lvl, jogf_lvl, jogr_lvl;
  logic key_run_q, key_stop_q, fwd_q, rev_q; // previous levels
  logic run_rise, stop_rise, fwd_rise, rev_rise; // closing edges

  // each input takes the role its function field names
  assign fwd_lvl = di_any(di_level, input_function_select,
                          drc_pkg::FN_FWD);
  assign rev_lvl = di_any(di_level, input_function_select,
                          drc_pkg::FN_REV);
  assign permit_lvl = di_any(di_level, input_function_select,
                             drc_pkg::FN_PERMIT);
  assign jogf_lvl = di_any(di_level, input_function_select,
                           drc_pkg::FN_JOG_FWD);
  assign jogr_lvl = di_any(di_level, input_function_select,
                           drc_pkg::FN_JOG_REV);

  // edge memory; a run key or start button held through reset does not start the drive
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      key_run_q <= 1'b1;
      key_stop_q <= 1'b1;
      fwd_q <= 1'b1;
      rev_q <= 1'b1;
    end else begin
      key_run_q <= key_run;
      key_stop_q <= key_stop;
      fwd_q <= fwd_lvl;
      rev_q <= rev_lvl;
    end
  end
  assign run_rise = key_run && !key_run_q;
  assign stop_rise = key_stop && !key_stop_q;
  assign fwd_rise = fwd_lvl && !fwd_q;
  assign rev_rise = rev_lvl && !rev_q;

  // ------------------------------------------------------------
  // request of the selected source only
  // ------------------------------------------------------------
  drc_pkg::drc_req_t req; // requests seen by the run state
  logic two_one; // exactly one two-wire switch closed

  assign two_one = fwd_lvl ^ rev_lvl;

  always_comb begin
    req = '0;
    case (command_source_select)
      drc_pkg::SRC_PANEL: begin
        req.start = run_rise;
        req.stop = stop_rise;
        req.jog = key_jog;
        req.jog_rev = key_multi && !reverse_inhibit &&
          (multifunction_key_select == drc_pkg::MFK_REV_JOG);
      end
      drc_pkg::SRC_TERM: begin
        req.jog = jogf_lvl;
        req.jog_rev = jogr_lvl;
        if (terminal_command_scheme == drc_pkg::SCHEME_3W) begin
          // reverse edge wins a tie, it is the later press to honour
          req.start = permit_lvl && (fwd_rise || rev_rise);
          req.rev = rev_rise;
          req.stop = !permit_lvl;
        end else begin
          req.start = two_one;
          req.rev = rev_lvl;
          req.stop = !two_one;
        end
      end
      drc_pkg::SRC_COMM: begin
        // commands decoded by the modbus slave front end
        req.start = comm_run_fwd || comm_run_rev;
        req.rev = comm_run_rev;
        req.stop = comm_stop;
      end
      default: begin
        req = '0; // reserved code: no source at all
      end
    endcase
  end

  // ------------------------------------------------------------
  // stop timers
  // ------------------------------------------------------------
  drc_pkg::drc_state_t state_r; // run state
  logic comm_sel; // comm is the active source
  logic comm_expired; // no valid frame within the timeout
  logic ts_expired; // timed stop duration elapsed
  logic comm_fault_r; // sticky comm timeout fault
  logic force_stop; // fault or timer forcing a stop
  logic [drc_pkg::TW-1:0] ts_limit; // chosen timed stop duration

  assign comm_sel = command_source_select == drc_pkg::SRC_COMM;
  assign ts_limit = timed_stop_duration_source ? timed_stop_analog
                                               : timed_stop_duration_value;

  drc_tick_timer #(
    .W(drc_pkg::TW),
    .UNIT_TICKS(drc_pkg::COMM_UNIT_MS)
  ) u_comm_timer (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick_r),
    .enable(comm_sel && comm_timeout_time != '0),
    .restart(comm_frame_valid),
    .limit(comm_timeout_time),
    .expired(comm_expired)
  );

  drc_tick_timer #(
    .W(drc_pkg::TW),
    .UNIT_TICKS(drc_pkg::TS_UNIT_MS)
  ) u_timed_stop (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick_r),
    .enable(timed_stop_enable && state_r == drc_pkg::ST_RUN),
    .restart(1'b0),
    .limit(ts_limit),
    .expired(ts_expired)
  );

  // fault: a new expiry outranks a clear in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      comm_fault_r <= 1'b0;
    end else if (comm_expired && comm_sel) begin
      comm_fault_r <= 1'b1;
    end else if (comm_fault_clear) begin
      comm_fault_r <= 1'b0;
    end
  end
  assign force_stop = comm_fault_r || ts_expired;

  // ------------------------------------------------------------
  // run state
  // ------------------------------------------------------------
  logic dir_r; // 1 = reverse
  logic coast_r; // current stop coasts

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= drc_pkg::ST_IDLE;
      dir_r <= 1'b0;
      coast_r <= 1'b0;
    end else begin
      case (state_r)
        drc_pkg::ST_IDLE: begin
          // a pending fault keeps the drive down until cleared
          if (!force_stop && req.start) begin
            state_r <= drc_pkg::ST_RUN;
            dir_r <= req.rev;
          end else if (!force_stop && (req.jog || req.jog_rev)) begin
            state_r <= drc_pkg::ST_JOG;
            dir_r <= !req.jog;
          end
        end
        drc_pkg::ST_RUN: begin
          if (req.stop || force_stop) begin
            state_r <= drc_pkg::ST_STOP;
            coast_r <= stop_mode_select == drc_pkg::STOP_COAST;
          end else if (req.start) begin
            dir_r <= req.rev;
          end
        end
        drc_pkg::ST_JOG: begin
          // jog release always ramps down
          if (force_stop || !(dir_r ? req.jog_rev : req.jog)) begin
            state_r <= drc_pkg::ST_STOP;
            coast_r <= 1'b0;
          end
        end
        drc_pkg::ST_STOP: begin
          if (coast_r || decel_done) begin
            state_r <= drc_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= drc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // start-up, control method and indicators
  // ------------------------------------------------------------
  logic [1:0] startup_r; // method frozen while running
  logic vector_r; // vector control selected
  logic source_led_r; // command source indicator
  logic run_led_r; // run indicator

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      startup_r <= drc_pkg::START_DIRECT;
    end else if (state_r == drc_pkg::ST_IDLE) begin
      // pre-excitation needs an induction motor, else start direct
      if (startup_mode_select == drc_pkg::START_TRACK ||
          (startup_mode_select == drc_pkg::START_PREEX &&
           motor_is_induction)) begin
        startup_r <= startup_mode_select;
      end else begin
        startup_r <= drc_pkg::START_DIRECT;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vector_r <= 1'b1;
    end else begin
      vector_r <= motor_control_method != drc_pkg::CTRL_VF;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      source_led_r <= 1'b0;
      run_led_r <= 1'b0;
    end else begin
      case (command_source_select)
        drc_pkg::SRC_TERM: source_led_r <= 1'b1;
        drc_pkg::SRC_COMM: source_led_r <= flash_r;
        default: source_led_r <= 1'b0;
      endcase
      run_led_r <= state_r == drc_pkg::ST_RUN ||
                   state_r == drc_pkg::ST_JOG;
    end
  end

  assign drive = {state_r == drc_pkg::ST_RUN || state_r == drc_pkg::ST_JOG,
                  dir_r, state_r == drc_pkg::ST_JOG,
                  state_r == drc_pkg::ST_STOP && !coast_r,
                  state_r == drc_pkg::ST_STOP && coast_r,
                  startup_r, vector_r};
  assign run_led = run_led_r;
  assign source_led = source_led_r;
  assign comm_fault = comm_fault_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_panel_idle;
    command_source_select == drc_pkg::SRC_PANEL &&
      state_r == drc_pkg::ST_IDLE && !force_stop;
  endsequence
  sequence s_comm_lost;
    comm_sel && comm_expired ##1 comm_fault_r;
  endsequence

  property p_panel_start;
    s_panel_idle and run_rise |=> state_r == drc_pkg::ST_RUN ##1 run_led;
  endproperty
  a_panel_start: assert property (p_panel_start)
    else $error("panel run key did not start the drive");

  property p_other_source_quiet;
    s_panel_idle and !run_rise && !key_jog && !key_multi
      |=> state_r == drc_pkg::ST_IDLE;
  endproperty
  a_other_source_quiet: assert property (p_other_source_quiet)
    else $error("a deselected source changed the run state");

  property p_two_wire_stop;
    command_source_select == drc_pkg::SRC_TERM && !terminal_command_scheme
      && state_r == drc_pkg::ST_RUN && fwd_lvl == rev_lvl
      |=> state_r == drc_pkg::ST_STOP;
  endproperty
  a_two_wire_stop: assert property (p_two_wire_stop)
    else $error("two-wire equal switches did not stop");

  property p_permit_open;
    command_source_select == drc_pkg::SRC_TERM && terminal_command_scheme
      && !permit_lvl && state_r != drc_pkg::ST_RUN
      |=> state_r != drc_pkg::ST_RUN;
  endproperty
  a_permit_open: assert property (p_permit_open)
    else $error("drive started with the stop permit open");

  property p_comm_shutdown;
    s_comm_lost ##0 state_r == drc_pkg::ST_RUN
      |=> state_r == drc_pkg::ST_STOP;
  endproperty
  a_comm_shutdown: assert property (p_comm_shutdown)
    else $error("comm timeout did not shut the drive down");

  property p_coast_stop;
    state_r == drc_pkg::ST_STOP && coast_r
      |-> drive.coast ##1 state_r == drc_pkg::ST_IDLE;
  endproperty
  a_coast_stop: assert property (p_coast_stop)
    else $error("coasting stop did not release at once");

  property p_jog_release;
    state_r == drc_pkg::ST_JOG && !dir_r && !req.jog
      |=> state_r == drc_pkg::ST_STOP && drive.decel;
  endproperty
  a_jog_release: assert property (p_jog_release)
    else $error("jog release did not ramp down");

  property p_led_term;
    command_source_select == drc_pkg::SRC_TERM |=> source_led;
  endproperty
  a_led_term: assert property (p_led_term)
    else $error("terminal source led not steady on");

  property p_vf_select;
    motor_control_method == drc_pkg::CTRL_VF [*2] |=> !drive.vector;
  endproperty
  a_vf_select: assert property (p_vf_select)
    else $error("v/f method still flagged as vector");

  property p_frame_no_fault;
    comm_sel && comm_frame_valid && !comm_fault_r
      |=> !comm_fault_r;
  endproperty
  a_frame_no_fault: assert property (p_frame_no_fault)
    else $error("fault raised right after a valid frame");
endmodule
`default_nettype wire

//--- drc_contacts.sv
// contact model for the terminal side: two switches and a permit button
`timescale 1ns/1ns
`default_nettype none
module drc_contacts (
  input wire logic close_fwd,
  input wire logic close_rev,
  input wire logic open_permit,
  output logic [9:0] di
);
  // ------------------------------------------------------------
  // wiring: forward on input two, permit on three, reverse on four
  // ------------------------------------------------------------
  always_comb begin
    di = 10'h000; // unwired inputs read open
    di[1] = close_fwd; // forward switch or start button
    di[3] = close_rev; // reverse switch or start button
    di[2] = ~open_permit; // permit stays closed unless told to open
  end
endmodule
`default_nettype wire

//--- tb_drc_top.sv
// self-checking bench for the drive run command logic
`timescale 1ns/1ns
`default_nettype none
module tb_drc_top;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [1:0] src = 2'h0;
  logic scheme = 1'h0;
  logic [9:0][3:0] fsel;
  logic [9:0] di;
  logic k_jog = 1'h0, no_permit = 1'h0, sw_rev = 1'h0, sw_fwd = 1'h0;
  logic k_run = 1'h0, k_stop = 1'h0, k_multi = 1'h0, rev_inh = 1'h1;
  logic c_frame = 1'h0, c_fwd = 1'h0, c_rev = 1'h0, c_stop = 1'h0;
  logic [2:0] mfk = 3'h0;
  logic [15:0] c_time = 16'h0000;
  logic [1:0] st_mode = 2'h0;
  logic [1:0] method = 2'h2;
  logic stop_coast = 1'h0, ts_en = 1'h0, dec_done = 1'h0;
  logic c_clr = 1'h0, induct = 1'h1;
  drc_pkg::drc_drive_t drive;
  logic run_led, source_led, comm_fault;
  int err_total = 0;
  int num_checks = 0;

  // short unit tick keeps the timers inside the run length
  drc_top #(.N_DI(10), .TICK_CYCLES(4)) u_drc_top (
    .clock(clock), .rstn(rstn), .command_source_select(src),
    .terminal_command_scheme(scheme), .input_function_select(fsel),
    .di_level(di), .key_run(k_run), .key_stop(k_stop), .key_jog(k_jog),
    .key_multi(k_multi), .multifunction_key_select(mfk),
    .reverse_inhibit(rev_inh), .comm_frame_valid(c_frame),
    .comm_run_fwd(c_fwd), .comm_run_rev(c_rev), .comm_stop(c_stop),
    .comm_timeout_time(c_time), .comm_fault_clear(c_clr),
    .startup_mode_select(st_mode), .motor_is_induction(induct),
    .stop_mode_select(stop_coast), .timed_stop_enable(ts_en),
    .timed_stop_duration_source(1'h0),
    .timed_stop_duration_value(16'h0000), .timed_stop_analog(16'h0000),
    .motor_control_method(method), .decel_done(dec_done), .drive(drive),
    .run_led(run_led), .source_led(source_led), .comm_fault(comm_fault)
  );
  drc_contacts u_drc_contacts (
    .close_fwd(sw_fwd), .close_rev(sw_rev), .open_permit(no_permit),
    .di(di)
  );

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(string n, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // one key pulse: 1 run, 2 stop
  task automatic press(int k);
    @(posedge clock);
    {k_stop, k_run} <= 2'(k);
    @(posedge clock);
    {k_stop, k_run} <= 2'h0;
  endtask
  // one host pulse: 1 fwd, 2 rev, 4 stop, 8 valid frame
  task automatic comm(logic [3:0] v);
    @(posedge clock);
    {c_frame, c_stop, c_rev, c_fwd} <= v;
    @(posedge clock);
    {c_frame, c_stop, c_rev, c_fwd} <= 4'h0;
  endtask
  // contacts and jog key as one level vector
  task automatic drv(logic [3:0] v);
    @(posedge clock);
    {k_jog, no_permit, sw_rev, sw_fwd} <= v;
  endtask
  // bounded wait on run; running out ends the run at once
  task automatic await_run(logic e);
    int i = 0;
    while (drive.run !== e && i < 6) begin
      step(1);
      i++;
    end
    chk("drive.run", e, drive.run);
    if (drive.run !== e) begin
      final_report();
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_panel();
    press(1);
    await_run(1'h1);
    chk("drive.vector", 1'h0, drive.vector);
    step(1);
    chk("run_led", 1'h1, run_led);
    chk("source_led", 1'h0, source_led);
    press(2);
    await_run(1'h0);
    chk("drive.decel", 1'h1, drive.decel);
    @(posedge clock);
    dec_done <= 1'h1;
    stop_coast <= 1'h1;
  endtask
  // jog release ramps even when coasting is chosen
  task automatic t_jog();
    drv(4'h8);
    await_run(1'h1);
    chk("drive.jog", 1'h1, drive.jog);
    chk("drive.reverse", 1'h0, drive.reverse);
    drv(4'h0);
    await_run(1'h0);
    chk("drive.decel", 1'h1, drive.decel);
    // reverse jog key refused while reverse is inhibited
    @(posedge clock);
    mfk <= 3'h4;
    k_multi <= 1'h1;
    step(4);
    chk("drive.run", 1'h0, drive.run);
    @(posedge clock);
    rev_inh <= 1'h0;
    await_run(1'h1);
    chk("drive.reverse", 1'h1, drive.reverse);
    @(posedge clock);
    k_multi <= 1'h0;
    await_run(1'h0);
  endtask
  task automatic t_two_wire();
    @(posedge clock);
    src <= 2'h1;
    press(1);
    step(4);
    chk("drive.run", 1'h0, drive.run);
    chk("source_led", 1'h1, source_led);
    drv(4'h1);
    await_run(1'h1);
    chk("drive.reverse", 1'h0, drive.reverse);
    drv(4'h3);
    await_run(1'h0);
    chk("drive.coast", 1'h1, drive.coast);
    drv(4'h2);
    await_run(1'h1);
    chk("drive.reverse", 1'h1, drive.reverse);
    drv(4'h0);
    await_run(1'h0);
  endtask
  // buttons act on their closing edge, latest wins, opening the permit stops
  task automatic t_three_wire();
    @(posedge clock);
    scheme <= 1'h1;
    drv(4'h1);
    drv(4'h0);
    await_run(1'h1);
    drv(4'h2);
    drv(4'h0);
    step(3);
    chk("drive.reverse", 1'h1, drive.reverse);
    drv(4'h4);
    await_run(1'h0);
  endtask
  // host start, frame keeps the link alive, silence trips the fault
  task automatic t_comm();
    int i;
    logic v;
    @(posedge clock);
    src <= 2'h2;
    c_time <= 16'h0001;
    st_mode <= 2'h2;
    induct <= 1'h0;
    step(2);
    comm(4'h1);
    await_run(1'h1);
    chk("drive.startup[1]", 1'h0, drive.startup[1]);
    step(300);
    comm(4'h8);
    step(300);
    chk("comm_fault", 1'h0, comm_fault);
    i = 0;
    while (comm_fault !== 1'h1 && i < 200) begin
      step(1);
      i++;
    end
    chk("comm_fault", 1'h1, comm_fault);
    if (comm_fault !== 1'h1) begin
      final_report();
    end
    await_run(1'h0);
    // clear loses against a standing expiry, wins after a frame
    @(posedge clock);
    c_clr <= 1'h1;
    step(2);
    chk("comm_fault", 1'h1, comm_fault);
    comm(4'h8);
    step(2);
    chk("comm_fault", 1'h0, comm_fault);
    @(posedge clock);
    c_clr <= 1'h0;
    induct <= 1'h1;
    step(2);
    chk("drive.startup[1]", 1'h1, drive.startup[1]);
    comm(4'h2);
    await_run(1'h1);
    chk("drive.reverse", 1'h1, drive.reverse);
    comm(4'h4);
    await_run(1'h0);
    // comm source indicator must toggle within one flash phase
    v = source_led;
    i = 0;
    while (source_led === v && i < 1100) begin
      step(1);
      i++;
    end
    chk("source_led", !v, source_led);
    if (source_led === v) begin
      final_report();
    end
  endtask

  initial begin
    fsel = '0;
    fsel[1] = drc_pkg::FN_FWD;
    fsel[2] = drc_pkg::FN_PERMIT;
    fsel[3] = drc_pkg::FN_REV;
    repeat (8) @(posedge clock);
    rstn <= 1'h1;
    step(4);
    t_panel();
    t_jog();
    t_two_wire();
    t_three_wire();
    t_comm();
    final_report();
  end
endmodule
`default_nettype wire
